// >>> core/ftcr_top.sv
/*
 Fan tachometer configuration registers with AHB-Lite access, the
 measurement scheduler, four tachometer channels, the shared alert or
 second-drive pin and a maskable interrupt.
 Assumes one master, word transfers only, and synchronous sense inputs.
*/
// Added by the designer: register access over AHB-Lite.
// Behaviour
// RL1 - Pin-function bit selects alert versus second drive
// RL2 - Fast bit shortens measurement period to 250 ms
// RL3 - Bits four to seven make channels measure continuously
// RL4 - Two-bit field sets pulses counted per fan
// RL5 - Pulse-count register resets to 0x55
// RL6 - Lock bit makes first test register read-only
// RL7 - Host avoids writing either test register
// RL8 - Config bits one, two are plain storage
// RL9 - Fan mask bit blocks that fault's alert
// RL10 - Setting changes apply from the next measurement
`timescale 1ns/1ps
`default_nettype none
`include "ftcr_params.svh"

module ftcr_top
    import ftcr_pkg::*;
#(
    parameter int unsigned SLOW_CYCLES =
        `FTCR_SLOW_PERIOD_MS * `FTCR_CLK_KHZ,
    parameter int unsigned FAST_CYCLES =
        `FTCR_FAST_PERIOD_MS * `FTCR_CLK_KHZ
)
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Speed-sense inputs
    input wire logic speed_sense_input_one_i,
    input wire logic speed_sense_input_two_i,
    input wire logic speed_sense_input_three_i,
    input wire logic speed_sense_input_four_i,
    // Shared pin
    input wire logic pwm_two_i,
    output logic second_fan_drive_output_o,
    output logic second_fan_drive_output_oe_o,
    // Results and interrupt
    output logic [63:0] fan_period_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [6:0] idx_reg;

    wire take = hsel_i & htrans_i[1] & hready_i;
    wire in_map = (haddr_i[31:9] == 23'h00_0000);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 7'h00;
        end
        else
        begin
            wr_pend_reg <= take & hwrite_i & in_map;
            rd_pend_reg <= take & ~hwrite_i & in_map;
            if (take)
            begin
                idx_reg <= haddr_i[8:2];
            end
        end
    end

    wire [7:0] wdata = hwdata_i[7:0];
    wire wr_cfg3 = wr_pend_reg & (idx_reg == `FTCR_IDX_CFG_THREE);
    wire wr_pulses = wr_pend_reg & (idx_reg == `FTCR_IDX_PULSES);
    wire wr_test1 = wr_pend_reg & (idx_reg == `FTCR_IDX_TEST_ONE);
    wire wr_test2 = wr_pend_reg & (idx_reg == `FTCR_IDX_TEST_TWO);
    wire wr_mask2 = wr_pend_reg & (idx_reg == `FTCR_IDX_MASK_TWO);
    wire wr_lock = wr_pend_reg & (idx_reg == `FTCR_IDX_LOCK);
    wire wr_status = wr_pend_reg & (idx_reg == `FTCR_IDX_IRQ_STATUS);
    wire wr_imask = wr_pend_reg & (idx_reg == `FTCR_IDX_IRQ_MASK);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] cfg3_reg;
    logic [7:0] pulses_reg;
    logic [7:0] test1_reg;
    logic [7:0] test2_reg;
    logic [7:0] mask2_reg;
    logic lock_reg;
    logic [7:0] status_reg;
    logic [7:0] imask_reg;
    logic [7:0] status_next;
    logic [7:0] events;

    // Lock is sticky until reset so test logic cannot be reopened
    wire lock_next = lock_reg | (wr_lock & wdata[`FTCR_BIT_LOCK]);
    // Set wins over a write-one-to-clear in the same cycle
    assign status_next = (status_reg & ~(wr_status ? wdata : 8'h00))
        | events;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            cfg3_reg <= `FTCR_RST_CFG_THREE;
            pulses_reg <= `FTCR_RST_PULSES; // RL5
            test1_reg <= `FTCR_RST_TEST;
            test2_reg <= `FTCR_RST_TEST;
            mask2_reg <= `FTCR_RST_MASK_TWO;
            lock_reg <= 1'b0;
            status_reg <= `FTCR_RST_IRQ;
            imask_reg <= `FTCR_RST_IRQ;
        end
        else
        begin
            cfg3_reg <= wr_cfg3 ? wdata : cfg3_reg; // RL8
            pulses_reg <= wr_pulses ? wdata : pulses_reg;
            test1_reg <= (wr_test1 & ~lock_reg) ? wdata : test1_reg; // RL6
            test2_reg <= wr_test2 ? wdata : test2_reg;
            mask2_reg <= wr_mask2 ? wdata : mask2_reg;
            lock_reg <= lock_next;
            status_reg <= status_next;
            imask_reg <= wr_imask ? wdata : imask_reg;
        end
    end

    wire [7:0] rd_sel =
        (idx_reg == `FTCR_IDX_CFG_THREE) ? cfg3_reg :
        (idx_reg == `FTCR_IDX_PULSES) ? pulses_reg :
        (idx_reg == `FTCR_IDX_TEST_ONE) ? test1_reg :
        (idx_reg == `FTCR_IDX_TEST_TWO) ? test2_reg :
        (idx_reg == `FTCR_IDX_MASK_TWO) ? mask2_reg :
        (idx_reg == `FTCR_IDX_LOCK) ? {7'h00, lock_reg} :
        (idx_reg == `FTCR_IDX_IRQ_STATUS) ? status_reg :
        (idx_reg == `FTCR_IDX_IRQ_MASK) ? imask_reg : 8'h00;

    assign hrdata_o = rd_pend_reg ? {24'h00_0000, rd_sel} : 32'h0000_0000;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // ------------------------------------------------------------------
    // Measurement scheduler
    // ------------------------------------------------------------------
    logic [24:0] period_cnt_reg;
    logic fast_active_reg;

    wire [24:0] period_last = fast_active_reg ?
        25'(FAST_CYCLES - 1) : 25'(SLOW_CYCLES - 1);
    wire tick = (period_cnt_reg == period_last);

    // Rate is taken up only at a period boundary
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            period_cnt_reg <= 25'h000_0000;
            fast_active_reg <= 1'b0;
        end
        else
        begin
            period_cnt_reg <= tick ? 25'h000_0000 :
                period_cnt_reg + 25'h000_0001; // RL2
            if (tick)
            begin
                fast_active_reg <= cfg3_reg[`FTCR_BIT_FAST]; // RL2 RL10
            end
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    wire [3:0] sense = {speed_sense_input_four_i, speed_sense_input_three_i,
        speed_sense_input_two_i, speed_sense_input_one_i};
    wire [3:0] cont = cfg3_reg[`FTCR_BIT_CONT_LO +: 4];
    logic [3:0] busy;
    logic [3:0] done;
    logic [3:0] fault;
    logic [3:0] start;

    // A busy channel ignores the tick; its run finishes undisturbed
    assign start = {4{tick}} | (cont & ~busy); // RL3

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_chan
            ftcr_tach_chan u_chan (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .tach_i(sense[ch]),
                .start_i(start[ch]),
                .cfg_i(pulses_reg[2 * ch +: 2]), // RL4
                .busy_o(busy[ch]),
                .done_o(done[ch]),
                .fault_o(fault[ch]),
                .period_o(fan_period_o[16 * ch +: 16])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt and shared pin
    // ------------------------------------------------------------------
    assign events = {fault, done};
    assign irq_o = |(status_reg & imask_reg);

    wire [3:0] fan_mask = mask2_reg[`FTCR_BIT_MASK_FAN_LO +: 4];
    wire alert_active = |(status_reg[7:4] & ~fan_mask); // RL9
    wire alert_mode = cfg3_reg[`FTCR_BIT_ALERT_SEL];

    // Alert is open-drain and active low; drive mode is push-pull
    assign second_fan_drive_output_o = alert_mode ? 1'b0 : pwm_two_i; // RL1
    assign second_fan_drive_output_oe_o = alert_mode ? alert_active : 1'b1;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Separate count between ticks, so a broken period counter is caught
    logic [24:0] gap_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || tick)
        begin
            gap_reg <= 25'h000_0000;
        end
        else
        begin
            gap_reg <= gap_reg + 25'h000_0001;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_locked_test_write;
        lock_reg && wr_test1;
    endsequence

    sequence s_cfg3_write;
        wr_cfg3 ##1 1'b1;
    endsequence

    chk_alert_pin_drive: assert property ( // RL1
        alert_mode |-> second_fan_drive_output_oe_o == alert_active
        && !second_fan_drive_output_o)
        else $error("shared pin not acting as alert");

    chk_pwm_pin_drive: assert property ( // RL1
        !alert_mode |-> second_fan_drive_output_oe_o
        && second_fan_drive_output_o == pwm_two_i)
        else $error("shared pin not carrying the drive signal");

    chk_fast_period: assert property ( // RL2
        tick |-> gap_reg == (fast_active_reg ?
        25'(FAST_CYCLES - 1) : 25'(SLOW_CYCLES - 1)))
        else $error("measurement period length wrong");

    chk_rate_at_tick: assert property ( // RL2
        tick |=> fast_active_reg == $past(cfg3_reg[`FTCR_BIT_FAST]))
        else $error("rate not taken up at period end");

    chk_cont_restart: assert property ( // RL3
        (cont & ~busy) != 4'h0
        |=> (busy & $past(cont & ~busy)) == $past(cont & ~busy))
        else $error("continuous channel not restarted");

    chk_pulses_reset: assert property ( // RL5
        $past(!rst_n_i) |-> pulses_reg == 8'h55)
        else $error("pulse register reset value wrong");

    chk_test_locked: assert property ( // RL6
        s_locked_test_write |=> $stable(test1_reg))
        else $error("locked test register was written");

    chk_spare_store: assert property ( // RL8
        s_cfg3_write |-> cfg3_reg[2:1] == $past(wdata[2:1]))
        else $error("spare config bits not stored");

    chk_fan_mask: assert property ( // RL9
        alert_mode && (status_reg[7:4] & ~fan_mask) == 4'h0
        |-> !second_fan_drive_output_oe_o)
        else $error("masked fan fault raised the alert");

endmodule : ftcr_top
`default_nettype wire

// >>> core/ftcr_params.svh
/*
 Constants of the fan tachometer configuration block: register indices,
 reset values, field positions and timing figures.
 Assumes a 20 MHz core clock and word-aligned AHB-Lite register access.
*/
`ifndef FTCR_PARAMS_SVH
`define FTCR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define FTCR_IDX_MASK_TWO 7'h75
`define FTCR_IDX_CFG_THREE 7'h78
`define FTCR_IDX_PULSES 7'h7b
`define FTCR_IDX_TEST_ONE 7'h7e
`define FTCR_IDX_TEST_TWO 7'h7f
`define FTCR_IDX_LOCK 7'h40
`define FTCR_IDX_IRQ_STATUS 7'h41
`define FTCR_IDX_IRQ_MASK 7'h42

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FTCR_RST_CFG_THREE 8'h00
`define FTCR_RST_PULSES 8'h55
`define FTCR_RST_TEST 8'h00
`define FTCR_RST_MASK_TWO 8'h00
`define FTCR_RST_IRQ 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FTCR_BIT_ALERT_SEL 0
`define FTCR_BIT_FAST 3
`define FTCR_BIT_CONT_LO 4
`define FTCR_BIT_MASK_FAN_LO 2
`define FTCR_BIT_LOCK 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FTCR_CLK_KHZ 20000
`define FTCR_SLOW_PERIOD_MS 1000
`define FTCR_FAST_PERIOD_MS 250
`define FTCR_CNT_MAX 16'hffff

`endif

// >>> core/ftcr_pkg.sv
/*
 Types and shared decode functions of the fan tachometer block.
 Assumes the constants header is on the include path.
*/
`include "ftcr_params.svh"

package ftcr_pkg;

    typedef enum logic [1:0] {
        FTCR_IDLE = 2'b00,
        FTCR_ARM = 2'b01,
        FTCR_COUNT = 2'b11
    } ftcr_state_type;

    // Pulse-count field to number of pulses counted
    function automatic logic [2:0] ftcr_pulses(input logic [1:0] code);
        ftcr_pulses = {1'b0, code} + 3'h1;
    endfunction : ftcr_pulses

endpackage : ftcr_pkg

// >>> core/ftcr_tach_chan.sv
/*
 One tachometer channel: counts core clocks across a set number of
 speed-sense pulses and reports the period, or a fault on time-out.
 Assumes the sense input is synchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftcr_params.svh"

module ftcr_tach_chan
    import ftcr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Sense and control
    input wire logic tach_i,
    input wire logic start_i,
    input wire logic [1:0] cfg_i,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic fault_o,
    output logic [15:0] period_o
);

    ftcr_state_type state_reg;
    logic tach_prev_reg;
    logic [2:0] target_reg;
    logic [2:0] edges_reg;
    logic [15:0] cnt_reg;
    logic [15:0] period_reg;
    logic done_reg;
    logic fault_reg;

    wire rise = tach_i & ~tach_prev_reg;
    wire timeout = (cnt_reg == `FTCR_CNT_MAX);
    wire last_edge = rise & (edges_reg == target_reg - 3'h1);
    wire [15:0] cnt_inc = cnt_reg + 16'h0001;

    // Target is latched at start, so a later write waits for the next run
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= FTCR_IDLE;
            tach_prev_reg <= 1'b0;
            target_reg <= 3'h2;
            edges_reg <= 3'h0;
            cnt_reg <= 16'h0000;
            period_reg <= 16'h0000;
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
        end
        else
        begin
            tach_prev_reg <= tach_i;
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
            unique case (state_reg)
                FTCR_IDLE:
                begin
                    if (start_i)
                    begin
                        state_reg <= FTCR_ARM;
                        target_reg <= ftcr_pulses(cfg_i); // RL4 RL10
                        cnt_reg <= 16'h0000;
                        edges_reg <= 3'h0;
                    end
                end
                FTCR_ARM:
                begin
                    cnt_reg <= cnt_inc;
                    if (rise)
                    begin
                        state_reg <= FTCR_COUNT;
                        cnt_reg <= 16'h0000;
                    end
                    else if (timeout)
                    begin
                        state_reg <= FTCR_IDLE;
                        period_reg <= `FTCR_CNT_MAX;
                        done_reg <= 1'b1;
                        fault_reg <= 1'b1;
                    end
                end
                FTCR_COUNT:
                begin
                    cnt_reg <= cnt_inc;
                    if (last_edge)
                    begin
                        state_reg <= FTCR_IDLE;
                        period_reg <= cnt_inc;
                        done_reg <= 1'b1;
                    end
                    else if (timeout)
                    begin
                        state_reg <= FTCR_IDLE;
                        period_reg <= `FTCR_CNT_MAX;
                        done_reg <= 1'b1;
                        fault_reg <= 1'b1;
                    end
                    else if (rise)
                    begin
                        edges_reg <= edges_reg + 3'h1; // RL4
                    end
                end
                default:
                begin
                    state_reg <= FTCR_IDLE;
                end
            endcase
        end
    end

    assign busy_o = (state_reg != FTCR_IDLE);
    assign done_o = done_reg;
    assign fault_o = fault_reg;
    assign period_o = period_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_pulse_target: assert property ( // RL4
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg == FTCR_IDLE) && start_i
        |=> target_reg == {1'b0, $past(cfg_i)} + 3'h1)
        else $error("pulse target does not follow its field");

    chk_target_held: assert property ( // RL10
        @(posedge core_clk_i) disable iff (!rst_n_i)
        busy_o && $past(busy_o) |-> $stable(target_reg))
        else $error("pulse target changed during a measurement");

endmodule : ftcr_tach_chan
`default_nettype wire

// >>> tb/ftcr_fan_model.sv
/*
 Behavioural fan: a speed-sense line that rises once every PERIOD core
 clocks while running.
 Assumes it shares the core clock of the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module ftcr_fan_model #(
    parameter int PERIOD = 10
)
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Control and sense line
    input wire logic run_i,
    output logic tach_o
);
    int cnt_reg;

    // A stalled rotor leaves the line low, so no edge ever arrives
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || !run_i)
        begin
            cnt_reg <= 0;
            tach_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
            tach_o <= (cnt_reg < PERIOD / 2);
        end
    end
endmodule : ftcr_fan_model

`default_nettype wire

// >>> tb/fan_tach_config_regs_tb.sv
/*
 Self-checking bench: AHB-Lite register tasks, four fan models and
 directed sequences with expected values.
 Assumes the design files and the fan model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftcr_params.svh"

module fan_tach_config_regs_tb;
    localparam int CEIL = 95000;
    localparam logic [6:0] IDX_TAB [9] = '{`FTCR_IDX_CFG_THREE,
        `FTCR_IDX_PULSES, `FTCR_IDX_TEST_ONE, `FTCR_IDX_TEST_TWO,
        `FTCR_IDX_MASK_TWO, `FTCR_IDX_LOCK, `FTCR_IDX_IRQ_STATUS,
        `FTCR_IDX_IRQ_MASK, 7'h10};
    localparam logic [7:0] RST_TAB [9] = '{8'h00, 8'h55, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic pwm_two = 1'b0;
    logic [3:0] fan_run = 4'hf;
    wire logic [3:0] tach;
    wire logic [31:0] hrdata;
    wire logic hready;
    wire logic hresp;
    wire logic pin;
    wire logic pin_oe;
    wire logic irq;
    wire logic [63:0] period;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    logic [31:0] rd;

    always #25 clk = ~clk;

    for (genvar g = 0; g < 4; g++)
    begin : fan
        ftcr_fan_model #(.PERIOD(10 + 2 * g)) u_ftcr_fan_model (
            .core_clk_i(clk), .rst_n_i(rst_n), .run_i(fan_run[g]),
            .tach_o(tach[g]));
    end

    // Short periods keep the run brief; expectations use the same values
    ftcr_top #(.SLOW_CYCLES(200), .FAST_CYCLES(50)) u_ftcr_top (
        .core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .speed_sense_input_one_i(tach[0]),
        .speed_sense_input_two_i(tach[1]),
        .speed_sense_input_three_i(tach[2]),
        .speed_sense_input_four_i(tach[3]),
        .pwm_two_i(pwm_two), .second_fan_drive_output_o(pin),
        .second_fan_drive_output_oe_o(pin_oe), .fan_period_o(period),
        .irq_o(irq));

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == CEIL)
        begin
            miscompares++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    // Ready and read data are taken as they stand up to the ending edge
    task automatic wait_ready(output logic [31:0] d);
        logic rdy;
        rdy = 1'b0;
        d = 32'h0000_0000;
        while (rdy !== 1'b1)
        begin
            @(negedge clk);
            rdy = hready;
            d = hrdata;
            @(posedge clk);
        end
    endtask : wait_ready

    task automatic bus_req(input logic [6:0] idx, input logic wr);
        logic [31:0] unused;
        @(posedge clk);
        haddr <= {23'h00_0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready(unused);
        htrans <= 2'h0;
    endtask : bus_req

    task automatic wr_reg(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        bus_req(idx, 1'b1);
        hwdata <= {24'h00_0000, d};
        wait_ready(unused);
    endtask : wr_reg

    task automatic rd_reg(input logic [6:0] idx, output logic [31:0] d);
        bus_req(idx, 1'b0);
        wait_ready(d);
    endtask : rd_reg

    task automatic wait_status(input logic [7:0] m);
        rd_reg(`FTCR_IDX_IRQ_STATUS, rd);
        while ((rd[7:0] & m) !== m)
            rd_reg(`FTCR_IDX_IRQ_STATUS, rd);
    endtask : wait_status

    // Counts completions of one channel over a fixed number of polls
    task automatic count_done(input logic [7:0] m, output int cnt);
        cnt = 0;
        wr_reg(`FTCR_IDX_IRQ_STATUS, 8'hff);
        repeat (150)
        begin
            rd_reg(`FTCR_IDX_IRQ_STATUS, rd);
            if ((rd[7:0] & m) != 8'h00)
            begin
                cnt++;
                wr_reg(`FTCR_IDX_IRQ_STATUS, m);
            end
        end
    endtask : count_done

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        pwm_two <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            rd_reg(IDX_TAB[i], rd);
            check(rd, {24'h00_0000, RST_TAB[i]});
        end
        check({31'h0, hresp}, 32'h0);
        wr_reg(7'h10, 8'hff);
        rd_reg(7'h10, rd);
        check(rd, 32'h0000_0000);
        @(negedge clk);
        check({30'h0, pin_oe, pin}, 32'h3);
        wr_reg(`FTCR_IDX_CFG_THREE, 8'h06);
        pwm_two <= 1'b0;
        rd_reg(`FTCR_IDX_CFG_THREE, rd);
        check(rd, 32'h0000_0006);
        @(negedge clk);
        check({30'h0, pin_oe, pin}, 32'h2);
        wr_reg(`FTCR_IDX_CFG_THREE, 8'h00);
        // Test registers are written only in this isolated check
        wr_reg(`FTCR_IDX_TEST_ONE, 8'ha5);
        wr_reg(`FTCR_IDX_TEST_TWO, 8'h3c);
        rd_reg(`FTCR_IDX_TEST_ONE, rd);
        check(rd, 32'h0000_00a5);
        wr_reg(`FTCR_IDX_LOCK, 8'h01);
        wr_reg(`FTCR_IDX_TEST_ONE, 8'h5a);
        wr_reg(`FTCR_IDX_TEST_TWO, 8'hc3);
        rd_reg(`FTCR_IDX_TEST_ONE, rd);
        check(rd, 32'h0000_00a5);
        rd_reg(`FTCR_IDX_TEST_TWO, rd);
        check(rd, 32'h0000_00c3);
        rd_reg(`FTCR_IDX_LOCK, rd);
        check(rd, 32'h0000_0001);
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(`FTCR_IDX_PULSES, {4{c[1:0]}});
            wr_reg(`FTCR_IDX_IRQ_STATUS, 8'hff);
            wait_status(8'h0f);
            wr_reg(`FTCR_IDX_IRQ_STATUS, 8'hff);
            wait_status(8'h0f);
            for (int ch = 0; ch < 4; ch++)
                check({16'h0, period[16*ch+:16]},
                    (c + 1) * (10 + 2 * ch));
        end
        wr_reg(`FTCR_IDX_PULSES, 8'h55);
        count_done(8'h01, n);
        check({31'h0, n <= 3}, 32'h1);
        wr_reg(`FTCR_IDX_CFG_THREE, 8'h08);
        repeat (210) @(posedge clk);
        count_done(8'h01, n);
        check({31'h0, n >= 7}, 32'h1);
        for (int ch = 0; ch < 4; ch++)
        begin
            wr_reg(`FTCR_IDX_CFG_THREE, 8'h10 << ch);
            repeat (210) @(posedge clk);
            count_done(8'h01 << ch, n);
            check({31'h0, n >= 7}, 32'h1);
        end
        wr_reg(`FTCR_IDX_CFG_THREE, 8'h01);
        wr_reg(`FTCR_IDX_IRQ_MASK, 8'h80);
        fan_run[3] <= 1'b0;
        wr_reg(`FTCR_IDX_IRQ_STATUS, 8'hff);
        wait_status(8'h80);
        @(negedge clk);
        check({16'h0, period[63:48]}, 32'h0000_ffff);
        check({29'h0, irq, pin_oe, pin}, 32'h6);
        wr_reg(`FTCR_IDX_MASK_TWO, 8'h20);
        @(negedge clk);
        check({30'h0, irq, pin_oe}, 32'h2);
        wr_reg(`FTCR_IDX_IRQ_MASK, 8'h00);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        wr_reg(`FTCR_IDX_IRQ_MASK, 8'h80);
        wr_reg(`FTCR_IDX_IRQ_STATUS, 8'h80);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        // Second reset in mid-run: defaults return and the lock reopens
        wr_reg(`FTCR_IDX_PULSES, 8'h00);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`FTCR_IDX_PULSES, rd);
        check(rd, 32'h0000_0055);
        rd_reg(`FTCR_IDX_LOCK, rd);
        check(rd, 32'h0000_0000);
        check({31'h0, irq}, 32'h0);
        finish_test();
    end
endmodule : fan_tach_config_regs_tb

`default_nettype wire
